// File: include/vic_regs.svh
// register offsets, field positions, reset values and sizes of the interrupt controller
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH

`define VIC_NUM_SRC      21
`define VIC_NUM_EXT      4
`define VIC_IDX_W        5
`define VIC_NUM_SLOT     21
`define VIC_GMASK_BIT    21
`define VIC_ADDR_W       8

`define VIC_OFF_MODE     8'h00
`define VIC_OFF_PEND     8'h04
`define VIC_OFF_MASK     8'h08
`define VIC_OFF_SLOT0    8'h0c
`define VIC_OFF_STATUS   8'h60

`define VIC_RST_MODE     21'h000000
`define VIC_RST_PEND     21'h000000
`define VIC_RST_MASK     22'h3fffff
`define VIC_NONE_IDX     5'h1f

`endif

// File: include/vic_pkg.sv
// types shared by the interrupt controller files
package vic_pkg;
    typedef logic [20:0] srcvec_t;
    typedef logic [4:0]  index_t;

    typedef struct packed {
        logic    cyc;
        logic    stb;
        logic    we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wbreq_s;

    typedef struct packed {
        logic   valid;
        index_t index;
        logic   fast;
    } winner_s;
endpackage : vic_pkg

// File: logic/vic_prio_pick.sv
// picks the highest-ranked deliverable source of the wanted mode (normal or fast) among the priority slots
`timescale 1ns/1ns
`default_nettype none
`include "vic_regs.svh"

module vic_prio_pick (
    input  wire vic_pkg::srcvec_t                        live,
    input  wire vic_pkg::index_t [`VIC_NUM_SLOT-1:0]     slotIdx,
    input  wire vic_pkg::srcvec_t                        fastSel,
    input  wire logic                                    wantFast,
    output vic_pkg::winner_s                             win
);
    logic [`VIC_NUM_SLOT-1:0] hit;

    // RULE_07 slot holds index
    genvar g;
    generate
        for (g = 0; g < `VIC_NUM_SLOT; g++) begin : gSlot
            assign hit[g] = (slotIdx[g] < 5'(`VIC_NUM_SRC)) && live[slotIdx[g]]
                            && (fastSel[slotIdx[g]] == wantFast);
        end
    endgenerate

    // RULE_20 highest slot wins
    always_comb begin
        win.valid = 1'b0;
        win.index = `VIC_NONE_IDX;
        win.fast  = wantFast;
        for (int s = 0; s < `VIC_NUM_SLOT; s++) begin
            if (hit[s]) begin
                win.valid = 1'b1;
                win.index = slotIdx[s];
            end
        end
    end
endmodule : vic_prio_pick
`default_nettype wire

// File: logic/vectored_interrupt_controller.sv
// interrupt controller: pending, mask, mode, priority slots, wishbone slave
//
// Contract
// RULE_01: twenty-one sources with fixed indices
// RULE_02: sources from blocks and external pins
// RULE_03: per-source normal or fast mode
// RULE_04: one pending flag per source
// RULE_05: write one clears pending flag
// RULE_06: handler clears serviced pending flag
// RULE_07: slot field holds source index
// RULE_08: slots span priorities zero to twenty
// RULE_09: mask one blocks delivery
// RULE_10: mask zero and pending delivers
// RULE_11: global mask bit 21 blocks all
// RULE_12: masking never stops pending set
// RULE_13: clearing global mask resumes delivery
// RULE_14: indices 0-7 pins and serial ports
// RULE_15: indices 8-11 dma and timers
// RULE_16: indices 12-15 data link channels
// RULE_17: indices 16-20 ethernet and i2c
// RULE_18: reset sets all mask bits
// RULE_19: request lines follow deliverable sources
// RULE_20: highest slot identified to software
`timescale 1ns/1ns
`default_nettype none
`include "vic_regs.svh"

module vectored_interrupt_controller (
    input  wire logic          clk,
    input  wire logic          nrst,
    // wishbone classic slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic [31:0]        wb_dat_o,
    output logic               wb_ack_o,
    output logic               wb_err_o,
    // RULE_14 pins 0-3
    input  wire logic [3:0]    extIrq,
    input  wire logic [1:0]    uart0Irq,
    input  wire logic [1:0]    uart1Irq,
    // RULE_15 dma and timers
    input  wire logic [1:0]    generalDmaIrq,
    input  wire logic [1:0]    timerIrq,
    // RULE_16 link channels a tx, a rx, b tx, b rx
    input  wire logic [3:0]    linkIrq,
    // RULE_17 buffer_dma tx, rx, mac tx, rx
    input  wire logic [3:0]    ethIrq,
    input  wire logic          i2cIrq,
    output logic               irq,
    output logic               fast_interrupt_request
);
    vic_pkg::wbreq_s  req;
    vic_pkg::srcvec_t srcIn;
    vic_pkg::srcvec_t extMeta, next_extMeta;
    vic_pkg::srcvec_t srcSync, next_srcSync;
    vic_pkg::srcvec_t srcPrev, next_srcPrev;
    vic_pkg::srcvec_t pend, next_pend;
    vic_pkg::srcvec_t mode, next_mode;
    logic [21:0]      mask, next_mask;
    vic_pkg::index_t [`VIC_NUM_SLOT-1:0] slot, next_slot;
    vic_pkg::srcvec_t live;
    vic_pkg::winner_s winIrq, winFast;
    logic             ack, next_ack;
    logic             err, next_err;
    logic [31:0]      rdat, next_rdat;
    logic             irqQ, next_irqQ;
    logic             fastQ, next_fastQ;
    logic             wrStrobe;
    logic             hitMap;
    logic [31:0]      rdVal;
    logic [31:0]      wmask;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                   sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

    // RULE_01 fixed index order
    // RULE_02 internal blocks and pins together
    assign srcIn = {i2cIrq, ethIrq, linkIrq, timerIrq, generalDmaIrq,
                    uart1Irq, uart0Irq, extIrq};

    // only pins are async; internal requests synchronised too for uniform latency
    always_comb begin
        next_extMeta = srcIn;
        next_srcSync = extMeta;
        next_srcPrev = srcSync;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            extMeta <= '0;
            srcSync <= '0;
            srcPrev <= '0;
        end else begin
            extMeta <= next_extMeta;
            srcSync <= next_srcSync;
            srcPrev <= next_srcPrev;
        end
    end

    // single-cycle bus access, ack one cycle after strobe
    assign wrStrobe = req.cyc && req.stb && !ack && !err && req.we;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{req.sel[b]}};
        end
    end

    always_comb begin
        hitMap = 1'b1;
        rdVal  = 32'h0;
        if (req.adr == `VIC_OFF_MODE) begin
            rdVal = {11'h0, mode};
        end else if (req.adr == `VIC_OFF_PEND) begin
            rdVal = {11'h0, pend};
        end else if (req.adr == `VIC_OFF_MASK) begin
            rdVal = {10'h0, mask};
        end else if (req.adr == `VIC_OFF_STATUS) begin
            rdVal = {16'h0, winFast.valid, winFast.index, 2'h0, winIrq.valid, winIrq.index, 2'h0};
        end else if (req.adr >= `VIC_OFF_SLOT0 && req.adr[1:0] == 2'h0
                     && req.adr < 8'(`VIC_OFF_SLOT0 + 4 * `VIC_NUM_SLOT)) begin
            rdVal = {27'h0, slot[6'((req.adr - `VIC_OFF_SLOT0) >> 2)]};
        end else begin
            hitMap = 1'b0;
        end
    end

    always_comb begin
        next_ack  = req.cyc && req.stb && !ack && !err && hitMap;
        next_err  = req.cyc && req.stb && !ack && !err && !hitMap;
        // data only beside ack, zero again while the master still holds stb
        next_rdat = (req.cyc && req.stb && !ack && !err && !req.we && hitMap) ? rdVal : 32'h0;
        next_mode = mode;
        next_mask = mask;
        next_slot = slot;
        next_pend = pend;

        if (wrStrobe && hitMap) begin
            // RULE_03 mode register
            if (req.adr == `VIC_OFF_MODE) begin
                next_mode = (mode & ~wmask[20:0]) | (req.dat[20:0] & wmask[20:0]);
            end
            // RULE_09 RULE_11 mask register
            if (req.adr == `VIC_OFF_MASK) begin
                next_mask = (mask & ~wmask[21:0]) | (req.dat[21:0] & wmask[21:0]);
            end
            // RULE_07 RULE_08 slot write
            if (req.adr >= `VIC_OFF_SLOT0 && req.adr < `VIC_OFF_STATUS && wmask[0]) begin
                next_slot[6'((req.adr - `VIC_OFF_SLOT0) >> 2)] = req.dat[4:0];
            end
            // RULE_05 RULE_06 write one clears
            if (req.adr == `VIC_OFF_PEND) begin
                next_pend = pend & ~(req.dat[20:0] & wmask[20:0]);
            end
        end
        // RULE_04 RULE_12 rising request sets, wins over clear
        next_pend = next_pend | (srcSync & ~srcPrev);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack  <= 1'b0;
            err  <= 1'b0;
            rdat <= 32'h0;
            mode <= `VIC_RST_MODE;
            pend <= `VIC_RST_PEND;
            // RULE_18 all masked
            mask <= `VIC_RST_MASK;
            for (int s = 0; s < `VIC_NUM_SLOT; s++) begin
                slot[s] <= 5'(s);
            end
        end else begin
            ack  <= next_ack;
            err  <= next_err;
            rdat <= next_rdat;
            mode <= next_mode;
            pend <= next_pend;
            mask <= next_mask;
            slot <= next_slot;
        end
    end

    assign wb_ack_o = ack;
    assign wb_err_o = err;
    assign wb_dat_o = rdat;

    // RULE_09 RULE_10 RULE_11 RULE_13 deliverable set
    assign live = mask[`VIC_GMASK_BIT] ? '0 : (pend & ~mask[20:0]);

    vic_prio_pick uPickIrq (
        .live     (live),
        .slotIdx  (slot),
        .fastSel  (mode),
        .wantFast (1'b0),
        .win      (winIrq)
    );

    vic_prio_pick uPickFast (
        .live     (live),
        .slotIdx  (slot),
        .fastSel  (mode),
        .wantFast (1'b1),
        .win      (winFast)
    );

    // RULE_19 registered request lines
    always_comb begin
        next_irqQ  = |(live & ~mode);
        next_fastQ = |(live & mode);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqQ  <= 1'b0;
            fastQ <= 1'b0;
        end else begin
            irqQ  <= next_irqQ;
            fastQ <= next_fastQ;
        end
    end

    assign irq                    = irqQ;
    assign fast_interrupt_request = fastQ;
endmodule : vectored_interrupt_controller
`default_nettype wire

// File: verification/vic_monitor.sv
// bus and request-line assertions for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module vic_monitor (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        irq,
    input wire logic        fast_interrupt_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence wr_s(a, d);
        wb_ack_o && wb_we_i && wb_adr_i == a && wb_sel_i[2:0] == 3'h7 && wb_dat_i[20:0] == d;
    endsequence
    answer_next_a: assert property (take_s |=> wb_ack_o || wb_err_o) else $error("no answer");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
    unmapped_err_a: assert property (take_s ##0 wb_adr_i > 8'h60 |=> wb_err_o && !wb_ack_o) else $error("no err");
    global_block_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h08 && wb_sel_i[2] && wb_dat_i[21]
        |-> ##[1:2] !irq && !fast_interrupt_request) else $error("global mask ignored");
    all_masked_a: assert property (wr_s(8'h08, 21'h1fffff)
        |-> ##[1:2] !irq && !fast_interrupt_request) else $error("mask ignored");
    pend_clear_a: assert property (wr_s(8'h04, 21'h1fffff)
        |-> ##[1:2] !irq && !fast_interrupt_request) else $error("clear ignored");
    mode_normal_a: assert property (wr_s(8'h00, 21'h0) |-> ##[1:2] !fast_interrupt_request)
        else $error("fast without mode");
endmodule : vic_monitor
bind vectored_interrupt_controller vic_monitor u_mon (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq(irq),
    .fast_interrupt_request(fast_interrupt_request));
`default_nettype wire

// File: verification/core_model.sv
// core model: counts rises of the normal and fast request lines
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic irq,
    input  wire logic fastReq,
    output var  int   nIrq,
    output var  int   nFast
);
    logic [1:0] last;
    // level lines, so one request per rise
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last <= 2'h0;
            nIrq <= 0;
            nFast <= 0;
        end else begin
            last <= {irq, fastReq};
            nIrq <= nIrq + int'(irq && !last[1]);
            nFast <= nFast + int'(fastReq && !last[0]);
        end
    end
endmodule : core_model
`default_nettype wire

// File: verification/vectored_interrupt_controller_tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "vic_regs.svh"
module vectored_interrupt_controller_tb;
    logic             clk;
    logic             nrst;
    vic_pkg::wbreq_s  req;
    vic_pkg::srcvec_t src;
    logic [31:0]      rdat;
    logic [31:0]      dout;
    logic             ack;
    logic             err;
    logic             rerr;
    logic             irq;
    logic             fast;
    int               nIrq;
    int               nFast;
    int               num_errors = 0;
    int               n_compared = 0;
    int               cycles = 0;
    vectored_interrupt_controller u_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
        .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(dout),
        .wb_ack_o(ack), .wb_err_o(err), .extIrq(src[3:0]), .uart0Irq(src[5:4]), .uart1Irq(src[7:6]),
        .generalDmaIrq(src[9:8]), .timerIrq(src[11:10]), .linkIrq(src[15:12]), .ethIrq(src[19:16]),
        .i2cIrq(src[20]), .irq(irq), .fast_interrupt_request(fast));
    core_model u_core (.clk(clk), .nrst(nrst), .irq(irq), .fastReq(fast), .nIrq(nIrq), .nFast(nFast));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // ack sampled at the rising edge as a master flop would; only the bench timeout ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b1, w, 4'hf, a, d};
        do begin
            @(posedge clk);
        end while (!(ack || err));
        rdat = dout;
        rerr = err;
        req <= '0;
    endtask : wb
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic t_reset();
        wb(1'b0, `VIC_OFF_MODE, 32'h0);
        chk("mode", 32'h0, rdat);
        wb(1'b0, `VIC_OFF_MASK, 32'h0);
        chk("mask", 32'h003fffff, rdat);
        $display("reset test done");
    endtask : t_reset
    task automatic t_pend();
        for (int i = 0; i < `VIC_NUM_SRC; i++) begin
            @(posedge clk);
            src[i] <= 1'b1;
            repeat (2) @(posedge clk);
            src[i] <= 1'b0;
            repeat (4) @(posedge clk);
            wb(1'b0, `VIC_OFF_PEND, 32'h0);
            chk("pend", (32'h2 << i) - 32'h1, rdat);
        end
        settle();
        chk("irq", 32'h0, 32'(irq));
        $display("pending test done");
    endtask : t_pend
    task automatic t_mask();
        wb(1'b1, `VIC_OFF_MASK, 32'h00200000);
        settle();
        chk("irq", 32'h0, 32'(irq));
        wb(1'b1, `VIC_OFF_MASK, 32'h001fffff);
        settle();
        chk("irq", 32'h0, 32'(irq));
        wb(1'b1, `VIC_OFF_MASK, 32'h0);
        settle();
        chk("irq", 32'h1, 32'(irq));
        chk("core", 32'h1, 32'(nIrq));
        // no fast winner, normal winner source 20
        wb(1'b0, `VIC_OFF_STATUS, 32'h0);
        chk("status", 32'h00007cd0, rdat);
        $display("mask test done");
    endtask : t_mask
    task automatic t_prio();
        // source 3 moved into top slot 20
        wb(1'b1, `VIC_OFF_SLOT0 + 8'h50, 32'h3);
        wb(1'b0, `VIC_OFF_STATUS, 32'h0);
        chk("status", 32'h00007c8c, rdat);
        wb(1'b1, `VIC_OFF_MODE, 32'h8);
        settle();
        chk("fast", 32'h1, 32'(nFast));
        wb(1'b0, `VIC_OFF_STATUS, 32'h0);
        chk("status", 32'h00008ccc, rdat);
        wb(1'b1, `VIC_OFF_MODE, 32'h0);
        settle();
        chk("fast", 32'h0, 32'(fast));
        $display("priority test done");
    endtask : t_prio
    task automatic t_clear();
        wb(1'b1, `VIC_OFF_PEND, 32'h0);
        wb(1'b0, `VIC_OFF_PEND, 32'h0);
        chk("pend", 32'h001fffff, rdat);
        wb(1'b1, `VIC_OFF_PEND, 32'h001fffff);
        settle();
        chk("irq", 32'h0, 32'(irq));
        wb(1'b0, 8'h70, 32'h0);
        chk("err", 32'h1, 32'(rerr));
        $display("clear test done");
    endtask : t_clear
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    initial begin
        nrst = 1'b0;
        req = '0;
        src = '0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_pend();
        t_mask();
        t_prio();
        t_clear();
        complete_run();
    end
endmodule : vectored_interrupt_controller_tb
`default_nettype wire
